//--- logic/rtc_status_trickle_regs.sv
// Control, status and charger registers behind a four-wire serial slave port.
// Assumes the serial clock is far slower than clk (80 ns against 10 ns) so that
// every serial edge is seen after the two-stage synchronisers.
module rtc_status_trickle_regs #(
   parameter rtc_regs_pkg::variant_t VARIANT   = rtc_regs_pkg::VAR_COMBINED,
   parameter logic                   CLK_PHASE = 1'b1
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       cs_n,
   input  wire logic       sclk,
   input  wire logic       din,
   output logic            dout_o,
   output logic            dout_oe,
   input  wire logic       osc_running,
   input  wire logic       alarm_match,
   input  wire logic       wave_in,
   output logic            osc_stop_on_battery,
   output logic            backup_output_enable,
   output logic            wave_rate_hi,
   output logic            wave_rate_lo,
   output logic            wave_irq_n,
   output logic            wave_pin_out,
   output logic            irq_n,
   output logic            charger_on,
   output logic            diode_on,
   output logic [1:0]      resistor_select
);

   // Sync stages: cs_n, sclk, din, osc_running, wave_in
   logic [4:0] meta_q;
   logic [4:0] sync_q;
   logic [4:0] prev_q;

   // First stage feeds only the second; edges come from stages two and three
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 5'h1F;
         sync_q <= 5'h1F;
         prev_q <= 5'h1F;
      end else begin
         meta_q <= {wave_in, osc_running, din, sclk, cs_n};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   logic cs_s, sclk_s, din_s, osc_s, wave_s;
   logic sclk_rise, sclk_fall, osc_fell;
   assign cs_s      = sync_q[0];
   assign sclk_s    = sync_q[1];
   assign din_s     = sync_q[2];
   assign osc_s     = sync_q[3];
   assign wave_s    = sync_q[4];
   assign sclk_rise = sclk_s & ~prev_q[1];
   assign sclk_fall = ~sclk_s & prev_q[1];
   assign osc_fell  = ~osc_s & prev_q[3];

   rtc_regs_pkg::state_t state_q;
   logic       cpol_q;
   logic [2:0] bit_q;
   logic [2:0] out_cnt_q;
   logic [7:0] in_sr_q;
   logic [7:0] out_sr_q;
   logic [6:0] addr_q;
   logic [7:0] ctrl_q;
   logic [7:0] chg_q;
   logic       osf_q;
   logic       af_q;

   // Edge roles follow host polarity against the strapped phase
   logic latch_edge, shift_edge;
   assign latch_edge = (cpol_q == CLK_PHASE) ? sclk_rise : sclk_fall;
   assign shift_edge = (cpol_q == CLK_PHASE) ? sclk_fall : sclk_rise;

   logic [7:0] in_byte;
   logic       byte_done;
   logic       wr_en;
   logic [6:0] addr_next;
   assign in_byte   = {in_sr_q[6:0], din_s};
   assign byte_done = latch_edge && (bit_q == rtc_regs_pkg::BIT_LAST);
   assign wr_en     = (state_q == rtc_regs_pkg::ST_WR) && byte_done;
   // Low nibble wraps alone, so 0Fh goes to 00h and 7Fh to 70h
   assign addr_next = {addr_q[6:4], addr_q[3:0] + 4'h1};

   // Read mux; unowned addresses read zero
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      case (addr_q)
         rtc_regs_pkg::ADDR_CONTROL: rd_byte = ctrl_q & rtc_regs_pkg::CTL_READ_MASK;
         rtc_regs_pkg::ADDR_STATUS: begin
            rd_byte[rtc_regs_pkg::STS_OSF] = osf_q;
            rd_byte[rtc_regs_pkg::STS_AF]  = af_q;
         end
         rtc_regs_pkg::ADDR_CHARGER: rd_byte = chg_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // Transfer sequencer; chip select high forces idle at once
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= rtc_regs_pkg::ST_IDLE;
         cpol_q  <= 1'b0;
      end else if (cs_s) begin
         state_q <= rtc_regs_pkg::ST_IDLE;
      end else begin
         case (state_q)
            rtc_regs_pkg::ST_IDLE: begin
               state_q <= rtc_regs_pkg::ST_ADDR;
               cpol_q  <= sclk_s;                // Idle level gives polarity
            end
            rtc_regs_pkg::ST_ADDR: begin
               if (byte_done) begin
                  state_q <= in_byte[rtc_regs_pkg::WR_FLAG_BIT] ? rtc_regs_pkg::ST_WR
                                                                : rtc_regs_pkg::ST_RD;
               end
            end
            rtc_regs_pkg::ST_WR: state_q <= rtc_regs_pkg::ST_WR;
            rtc_regs_pkg::ST_RD: state_q <= rtc_regs_pkg::ST_RD;
            default: state_q <= rtc_regs_pkg::ST_IDLE;
         endcase
      end
   end

   // Input shifter and bit counter, MSB first
   always_ff @(posedge clk) begin
      if (rst || state_q == rtc_regs_pkg::ST_IDLE) begin
         bit_q   <= rtc_regs_pkg::BIT_FIRST;
         in_sr_q <= 8'h00;
      end else if (latch_edge) begin
         bit_q   <= bit_q + 3'h1;
         in_sr_q <= in_byte;
      end
   end

   // Address pointer: taken from first byte, then advanced per data byte
   logic rd_load;
   assign rd_load = (state_q == rtc_regs_pkg::ST_RD) && shift_edge
                    && (out_cnt_q == rtc_regs_pkg::BIT_FIRST);
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_q <= 7'h00;
      end else if (state_q == rtc_regs_pkg::ST_ADDR && byte_done) begin
         addr_q <= in_byte[6:0];
      end else if (wr_en || rd_load) begin
         addr_q <= addr_next;
      end
   end

   // Output shifter; a byte is fetched whole before its first bit leaves
   always_ff @(posedge clk) begin
      if (rst || state_q != rtc_regs_pkg::ST_RD) begin
         out_cnt_q <= rtc_regs_pkg::BIT_FIRST;
         out_sr_q  <= 8'h00;
         dout_o    <= 1'b1;
      end else if (shift_edge) begin
         out_cnt_q <= out_cnt_q + 3'h1;
         if (rd_load) begin
            dout_o   <= rd_byte[7];
            out_sr_q <= {rd_byte[6:0], 1'b0};
         end else begin
            dout_o   <= out_sr_q[7];
            out_sr_q <= {out_sr_q[6:0], 1'b0};
         end
      end
   end

   // Driven only in read data phase; writes and idle leave the line free
   always_ff @(posedge clk) begin
      if (rst) begin
         dout_oe <= 1'b0;
      end else begin
         dout_oe <= (state_q == rtc_regs_pkg::ST_RD) && !cs_s;
      end
   end

   // Control and charger storage; every variant keeps all writable bits
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= rtc_regs_pkg::CTL_RESET;
         chg_q  <= rtc_regs_pkg::CHG_RESET;
      end else if (wr_en) begin
         if (addr_q == rtc_regs_pkg::ADDR_CONTROL) begin
            ctrl_q <= in_byte & rtc_regs_pkg::CTL_READ_MASK;
         end
         if (addr_q == rtc_regs_pkg::ADDR_CHARGER) begin
            chg_q <= in_byte;
         end
      end
   end

   // Sticky flags: a hardware set wins over a same-cycle clear
   logic sts_wr;
   assign sts_wr = wr_en && (addr_q == rtc_regs_pkg::ADDR_STATUS);
   always_ff @(posedge clk) begin
      if (rst) begin
         osf_q <= rtc_regs_pkg::OSF_RESET;
         af_q  <= 1'b0;
      end else begin
         if (osc_fell) begin
            osf_q <= 1'b1;
         end else if (sts_wr && !in_byte[rtc_regs_pkg::STS_OSF]) begin
            osf_q <= 1'b0;
         end
         if (alarm_match) begin
            af_q <= 1'b1;
         end else if (sts_wr && !in_byte[rtc_regs_pkg::STS_AF]) begin
            af_q <= 1'b0;
         end
      end
   end

   // Pin functions decoded per variant; the reset-pin part drives only osc_stop_on_battery and the charger outputs
   logic mode_bit, alarm_on, func_on;
   logic [3:0] key;
   logic [1:0] dsel, rsel;
   logic chg_ok;
   assign mode_bit = ctrl_q[rtc_regs_pkg::CTL_MODE];
   assign alarm_on = af_q && ctrl_q[rtc_regs_pkg::CTL_AIE];
   assign func_on  = (VARIANT != rtc_regs_pkg::VAR_RESET_PIN);
   assign key      = chg_q[7:4];
   assign dsel     = chg_q[3:2];
   assign rsel     = chg_q[1:0];
   assign chg_ok   = (key == rtc_regs_pkg::CHG_KEY)
                     && (dsel == rtc_regs_pkg::DIODE_NONE || dsel == rtc_regs_pkg::DIODE_ONE)
                     && (rsel != rtc_regs_pkg::RES_OFF);

   always_ff @(posedge clk) begin
      if (rst) begin
         osc_stop_on_battery  <= 1'b0;
         backup_output_enable <= 1'b0;
         wave_rate_hi         <= 1'b0;
         wave_rate_lo         <= 1'b0;
         wave_irq_n           <= 1'b1;
         wave_pin_out         <= 1'b1;
         irq_n                <= 1'b1;
         charger_on           <= 1'b0;
         diode_on             <= 1'b0;
         resistor_select      <= 2'h0;
      end else begin
         osc_stop_on_battery  <= ctrl_q[rtc_regs_pkg::CTL_OSC_STOP];
         backup_output_enable <= func_on && ctrl_q[rtc_regs_pkg::CTL_BACKUP];
         wave_rate_hi         <= func_on && ctrl_q[rtc_regs_pkg::CTL_RATE_HI];
         wave_rate_lo         <= func_on && ctrl_q[rtc_regs_pkg::CTL_RATE_LO];
         wave_irq_n   <= 1'b1;
         wave_pin_out <= 1'b1;
         irq_n        <= 1'b1;
         if (VARIANT == rtc_regs_pkg::VAR_COMBINED) begin
            wave_irq_n <= mode_bit ? !alarm_on : wave_s;
         end else if (VARIANT == rtc_regs_pkg::VAR_SPLIT_PIN) begin
            wave_pin_out <= mode_bit ? 1'b1 : wave_s;
            irq_n        <= !alarm_on;
         end
         charger_on      <= chg_ok;
         diode_on        <= chg_ok && (dsel == rtc_regs_pkg::DIODE_ONE);
         resistor_select <= chg_ok ? rsel : rtc_regs_pkg::RES_OFF;
      end
   end

   property p_osf_set;
      @(posedge clk) disable iff (rst) osc_fell |=> osf_q;
   endproperty
   a_osf_set: assert property (p_osf_set) else $error("stop flag missed a halt");

   property p_osf_hold;
      @(posedge clk) disable iff (rst)
         osf_q && !(sts_wr && !in_byte[rtc_regs_pkg::STS_OSF]) |=> osf_q;
   endproperty
   a_osf_hold: assert property (p_osf_hold) else $error("stop flag lost");

   property p_af_set;
      @(posedge clk) disable iff (rst) alarm_match |=> af_q;
   endproperty
   a_af_set: assert property (p_af_set) else $error("alarm flag missed");

   property p_af_clear;
      @(posedge clk) disable iff (rst)
         sts_wr && !in_byte[rtc_regs_pkg::STS_AF] && !alarm_match |=> !af_q;
   endproperty
   a_af_clear: assert property (p_af_clear) else $error("alarm flag not cleared");

   property p_charger;
      @(posedge clk) disable iff (rst)
         charger_on |-> $past(key) == rtc_regs_pkg::CHG_KEY && $past(rsel) != rtc_regs_pkg::RES_OFF;
   endproperty
   a_charger: assert property (p_charger) else $error("charger on without key");

   property p_cs_quiet;
      @(posedge clk) disable iff (rst) cs_s ##1 cs_s |-> !dout_oe;
   endproperty
   a_cs_quiet: assert property (p_cs_quiet) else $error("output driven while deselected");

   property p_write_quiet;
      @(posedge clk) disable iff (rst) state_q == rtc_regs_pkg::ST_WR |=> !dout_oe;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("output driven on write");

   property p_wrap;
      @(posedge clk) disable iff (rst) wr_en && addr_q == rtc_regs_pkg::ADDR_CHARGER |=> addr_q == 7'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("burst address wrap wrong");

   property p_irq;
      @(posedge clk) disable iff (rst)
         VARIANT == rtc_regs_pkg::VAR_COMBINED && mode_bit && alarm_on ##1 mode_bit |-> !wave_irq_n;
   endproperty
   a_irq: assert property (p_irq) else $error("alarm not on combined pin");

   property p_addr_quiet;
      @(posedge clk) disable iff (rst) state_q == rtc_regs_pkg::ST_ADDR |=> !dout_oe;
   endproperty
   a_addr_quiet: assert property (p_addr_quiet) else $error("output driven before a byte is ready");

   property p_af_hold;
      @(posedge clk) disable iff (rst) af_q && !(sts_wr && !in_byte[rtc_regs_pkg::STS_AF]) |=> af_q;
   endproperty
   a_af_hold: assert property (p_af_hold) else $error("alarm flag lost");

   property p_key_off;
      @(posedge clk) disable iff (rst) key != rtc_regs_pkg::CHG_KEY |=> !charger_on;
   endproperty
   a_key_off: assert property (p_key_off) else $error("charger on with wrong key");

   property p_diode_off;
      @(posedge clk) disable iff (rst) !(dsel == rtc_regs_pkg::DIODE_NONE || dsel == rtc_regs_pkg::DIODE_ONE) |=> !charger_on;
   endproperty
   a_diode_off: assert property (p_diode_off) else $error("charger on with bad diode field");

   property p_res_off;
      @(posedge clk) disable iff (rst) rsel == rtc_regs_pkg::RES_OFF |=> !charger_on && resistor_select == rtc_regs_pkg::RES_OFF;
   endproperty
   a_res_off: assert property (p_res_off) else $error("charger on with no resistor");

   property p_split_wave;
      @(posedge clk) disable iff (rst) VARIANT == rtc_regs_pkg::VAR_SPLIT_PIN && mode_bit |=> wave_pin_out;
   endproperty
   a_split_wave: assert property (p_split_wave) else $error("wave pin not held off");

   property p_storage_only;
      @(posedge clk) disable iff (rst)
         VARIANT == rtc_regs_pkg::VAR_RESET_PIN |=> !backup_output_enable && !wave_rate_hi && !wave_rate_lo;
   endproperty
   a_storage_only: assert property (p_storage_only) else $error("storage bits drove a function");

endmodule : rtc_status_trickle_regs

//--- logic/rtc_regs_pkg.sv
// Constants, field positions and types for the serial clock register block.
// Assumes one system clock; serial pins arrive from outside that domain.
package rtc_regs_pkg;
   localparam logic [6:0] ADDR_CONTROL = 7'h0D;
   localparam logic [6:0] ADDR_STATUS  = 7'h0E;
   localparam logic [6:0] ADDR_CHARGER = 7'h0F;
   localparam int         WR_FLAG_BIT  = 7;

   localparam int CTL_OSC_STOP = 7;
   localparam int CTL_BACKUP   = 5;
   localparam int CTL_RATE_HI  = 4;
   localparam int CTL_RATE_LO  = 3;
   localparam int CTL_MODE     = 2;
   localparam int CTL_AIE      = 0;
   localparam int STS_OSF      = 7;
   localparam int STS_AF       = 0;

   localparam logic [7:0] CTL_READ_MASK = 8'hBD;
   localparam logic [7:0] CTL_RESET     = 8'h18;
   localparam logic [7:0] CHG_RESET     = 8'h00;
   localparam logic       OSF_RESET     = 1'b1;

   localparam logic [3:0] CHG_KEY    = 4'hA;
   localparam logic [1:0] DIODE_NONE = 2'h1;
   localparam logic [1:0] DIODE_ONE  = 2'h2;
   localparam logic [1:0] RES_OFF    = 2'h0;
   localparam logic [2:0] BIT_LAST   = 3'h7;
   localparam logic [2:0] BIT_FIRST  = 3'h0;

   typedef enum logic [1:0] {
      VAR_COMBINED  = 2'h0,
      VAR_RESET_PIN = 2'h1,
      VAR_SPLIT_PIN = 2'h2
   } variant_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_WR   = 4'h4,
      ST_RD   = 4'h8
   } state_t;
endpackage : rtc_regs_pkg

//--- tb/spi_host_model.sv
// Host side of the four-wire serial link, phase 1; clock idles high unless set_pol lowers it.
// Assumes clk at 100 MHz; serial half period is four clk cycles (80 ns period).
module spi_host_model (
   input  wire logic clk,
   input  wire logic dout_o,
   input  wire logic dout_oe,
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   output logic      quiet
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_q;
   logic line;
   logic pol;

   // Released data line shows the inverse of its last driven value
   always @(posedge clk) if (dout_oe) last_q <= dout_o;
   assign line = dout_oe ? dout_o : ~last_q;

   // Deselected and clock parked high at start
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
      quiet = 1'b1;
      last_q = 1'b0;
      pol = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_clk

   // Clock idle level changes only between frames, while deselected
   task automatic set_pol(input logic p);
      pol = p;
      sclk <= p;
      wait_clk(4);
   endtask : set_pol

   // One byte; data set on the leading edge, sampled late in the trailing phase
   task automatic shift_byte(input logic [7:0] tx, input logic q_after, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk <= ~pol;
         din <= tx[i];
         wait_clk(4);
         sclk <= pol;
         if (i == 0) quiet <= q_after;
         wait_clk(3);
         rx[i] = line;
         wait_clk(1);
      end
   endtask : shift_byte

   // Address byte first, then n data bytes taken from the top of tx
   task automatic frame(input logic [7:0] a, input int n, input logic [31:0] tx, output logic [31:0] rx);
      logic [7:0] b;
      rx = 32'h0;
      cs_n <= 1'b0;
      quiet <= 1'b1;
      wait_clk(4);
      shift_byte(a, a[7], b);
      for (int k = 0; k < n; k++) begin
         shift_byte(tx[31-8*k -: 8], a[7], b);
         rx[31-8*k -: 8] = b;
      end
      wait_clk(4);
      cs_n <= 1'b1;
      wait_clk(6);
   endtask : frame

   // Clock and data wiggle while deselected; the device must ignore it
   task automatic idle_noise(input int n);
      for (int i = 0; i < n; i++) begin
         sclk <= ~sclk;
         din <= i[1];
         wait_clk(4);
      end
      sclk <= pol;
      wait_clk(4);
   endtask : idle_noise
endmodule : spi_host_model

//--- tb/rtc_status_trickle_regs_bench.sv
// Self-checking bench for the control, status and charger registers.
// Assumes host phase 1; the split-pin and reset-pin variants ride on the same link.
module rtc_status_trickle_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, osc_running, alarm_match, wave_in;
   logic        cs_n, sclk, din, quiet, dout_o, dout_oe;
   logic        osc_stop_on_battery, backup_output_enable, wave_rate_hi, wave_rate_lo;
   logic        wave_irq_n, wave_pin_out, irq_n, charger_on, diode_on;
   logic [1:0]  resistor_select;
   logic        split_wave, split_irq_n, split_comb_n;
   logic        store_osc_stop, store_backup, store_rate_hi, store_rate_lo;
   logic [31:0] rx;
   int          miscompares, compares, cycles;
   // Row: written value, then charger_on, diode_on, resistor_select
   logic [11:0] rows [9] = '{12'hA59, 12'hAAE, 12'hA7B, 12'hABF, 12'hA80,
                             12'hAE0, 12'hA10, 12'hB50, 12'h5A0};

   rtc_status_trickle_regs dut_u (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout_o(dout_o), .dout_oe(dout_oe), .osc_running(osc_running), .alarm_match(alarm_match),
      .wave_in(wave_in), .osc_stop_on_battery(osc_stop_on_battery),
      .backup_output_enable(backup_output_enable), .wave_rate_hi(wave_rate_hi),
      .wave_rate_lo(wave_rate_lo), .wave_irq_n(wave_irq_n), .wave_pin_out(wave_pin_out),
      .irq_n(irq_n), .charger_on(charger_on), .diode_on(diode_on),
      .resistor_select(resistor_select));
   spi_host_model host_u (.clk(clk), .dout_o(dout_o), .dout_oe(dout_oe), .cs_n(cs_n),
      .sclk(sclk), .din(din), .quiet(quiet));
   // Other pin variants see every write; their read data is left unused
   rtc_status_trickle_regs #(.VARIANT(rtc_regs_pkg::VAR_SPLIT_PIN)) split_u (.clk(clk), .rst(rst),
      .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(), .dout_oe(), .osc_running(osc_running),
      .alarm_match(alarm_match), .wave_in(wave_in), .osc_stop_on_battery(), .backup_output_enable(),
      .wave_rate_hi(), .wave_rate_lo(), .wave_irq_n(split_comb_n), .wave_pin_out(split_wave),
      .irq_n(split_irq_n), .charger_on(), .diode_on(), .resistor_select());
   rtc_status_trickle_regs #(.VARIANT(rtc_regs_pkg::VAR_RESET_PIN)) store_u (.clk(clk), .rst(rst),
      .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(), .dout_oe(), .osc_running(osc_running),
      .alarm_match(alarm_match), .wave_in(wave_in), .osc_stop_on_battery(store_osc_stop),
      .backup_output_enable(store_backup), .wave_rate_hi(store_rate_hi), .wave_rate_lo(store_rate_lo),
      .wave_irq_n(), .wave_pin_out(), .irq_n(), .charger_on(), .diode_on(), .resistor_select());

   task automatic stop_test();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cycle ceiling; all frames together take about 5700 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         stop_test();
      end
   end

   // Data out must stay undriven through address bytes and write frames
   always @(posedge clk) if (!rst && quiet && dout_oe !== 1'b0) begin
      miscompares++;
      $display("[ERR] %0t dout driven while it should float", $time);
   end

   initial begin
      rst = 1'b1;
      osc_running = 1'b1;
      alarm_match = 1'b0;
      wave_in = 1'b1;
      miscompares = 0;
      compares = 0;
      cycles = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      // Power-up values; burst read wraps past the last register
      host_u.frame(8'h0D, 4, 32'h0, rx);
      chk(rx, 32'h1880_0000, "reset burst");
      chk({wave_irq_n, charger_on, wave_rate_hi, wave_rate_lo}, 4'hB, "reset pins");
      chk({wave_pin_out, irq_n, split_comb_n, split_wave, split_irq_n}, 5'h1F, "idle pins");
      chk({store_osc_stop, store_backup, store_rate_hi, store_rate_lo}, 4'h0, "storage reset");
      // Charger table: readback and decoded pins
      foreach (rows[i]) begin
         host_u.frame(8'h8F, 1, {rows[i][11:4], 24'h0}, rx);
         host_u.frame(8'h0F, 1, 32'h0, rx);
         chk(rx[31:24], rows[i][11:4], "charger readback");
         chk({charger_on, diode_on, resistor_select}, rows[i][3:0], "charger pins");
      end
      // Deselected noise must not disturb the last value written
      host_u.idle_noise(16);
      host_u.frame(8'h0F, 1, 32'h0, rx);
      chk(rx[31:24], 8'h5A, "noise ignored");
      // Alarm sets its flag; writing ones leaves both flags alone
      @(posedge clk) alarm_match <= 1'b1;
      @(posedge clk) alarm_match <= 1'b0;
      host_u.frame(8'h8E, 1, 32'hFF00_0000, rx);
      host_u.frame(8'h0E, 1, 32'h0, rx);
      chk(rx[31:24], 8'h81, "ones ignored");
      // Wave held low so a leaking square wave would show on the pins
      wave_in <= 1'b0;
      host_u.frame(8'h8D, 1, 32'h0500_0000, rx);
      chk(wave_irq_n, 1'b0, "alarm irq");
      chk({split_wave, split_irq_n}, 2'h2, "split enable off");
      host_u.frame(8'h8D, 1, 32'h0400_0000, rx);
      chk(wave_irq_n, 1'b1, "irq masked");
      chk({split_wave, split_irq_n}, 2'h3, "split masked");
      // Mode bit zero: square wave reaches the combined pin
      host_u.frame(8'h8D, 1, 32'h0100_0000, rx);
      wave_in <= 1'b0;
      repeat (6) @(posedge clk);
      chk(wave_irq_n, 1'b0, "wave low");
      chk({split_wave, split_irq_n}, 2'h0, "split wave on");
      wave_in <= 1'b1;
      repeat (6) @(posedge clk);
      chk(wave_irq_n, 1'b1, "wave high");
      host_u.frame(8'h8E, 1, 32'h0, rx);
      host_u.frame(8'h0E, 1, 32'h0, rx);
      chk(rx[31:24], 8'h00, "zero clears");
      // Stop edge sets the flag once; a held low level does not set it again
      osc_running <= 1'b0;
      host_u.frame(8'h0E, 1, 32'h0, rx);
      chk(rx[31:24], 8'h80, "osc stop");
      host_u.frame(8'h8E, 1, 32'h0, rx);
      host_u.frame(8'h0E, 1, 32'h0, rx);
      chk(rx[31:24], 8'h00, "edge only");
      osc_running <= 1'b1;
      // Burst write over three registers, then burst read back
      host_u.frame(8'h8D, 3, 32'hFF81_A600, rx);
      host_u.frame(8'h0D, 3, 32'h0, rx);
      chk(rx, 32'hBD00_A600, "burst write");
      chk({osc_stop_on_battery, backup_output_enable, charger_on, resistor_select}, 5'h1E, "ctl pins");
      chk({store_osc_stop, store_backup, store_rate_hi, store_rate_lo}, 4'h8, "storage bits");
      // Clock idling low: latch and shift edges swap
      host_u.set_pol(1'b0);
      host_u.frame(8'h8F, 1, 32'hA900_0000, rx);
      host_u.frame(8'h0E, 2, 32'h0, rx);
      chk(rx, 32'h00A9_0000, "low idle");
      chk({charger_on, diode_on, resistor_select}, 4'hD, "low idle pins");
      host_u.set_pol(1'b1);
      // Mid-run reset brings back the power-up values
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      host_u.frame(8'h0D, 3, 32'h0, rx);
      chk(rx, 32'h1880_0000, "reset again");
      chk({charger_on, resistor_select, osc_stop_on_battery}, 4'h0, "reset again pins");
      stop_test();
   end
endmodule : rtc_status_trickle_regs_bench
